// ### rtl/bus_yield_map.svh
// Constants for the primary bus yield logic
// Assumes inclusion by bare name from rtl sources
`ifndef BUS_YIELD_MAP_SVH
`define BUS_YIELD_MAP_SVH
`define ADDR_WIDTH       24
`define DATA_WIDTH       32
`define GRANT_HOLD_CYC   1
`define RW_IDLE_VALUE    1'b1
`endif

// ### rtl/bus_yield_pkg.sv
// Types for the primary bus yield logic
// Assumes bus_yield_map.svh sits in the include path
`include "bus_yield_map.svh"
package bus_yield_pkg;
  typedef enum logic [2:0] {
    ST_OWN,
    ST_STROBE_HIGH,
    ST_YIELDED,
    ST_GRANT_TAIL,
    ST_RESUME
  } yield_state_t;

  typedef struct packed {
    logic                     rd;
    logic                     wr;
    logic [`ADDR_WIDTH-1:0]   addr;
    logic [`DATA_WIDTH-1:0]   wdata;
  } core_req_t;

  typedef struct packed {
    logic                     strobe_n;
    logic                     rw;
    logic [`ADDR_WIDTH-1:0]   addr;
    logic [`DATA_WIDTH-1:0]   data;
    logic                     ctl_oe;
    logic                     data_oe;
  } bus_drive_t;
endpackage

// ### rtl/pending_write_slot.sv
// Holds one posted primary-bus write
// Assumes the owner drains it when the bus returns
`timescale 1ns/100ps
`default_nettype none
module pending_write_slot
  import bus_yield_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire logic      rst_i,
  input  wire logic      load_i,
  input  wire core_req_t req_i,
  input  wire logic      drain_i,
  output logic           full_o,
  output core_req_t      slot_o
);
  logic      full_q;
  logic      full_d;
  core_req_t slot_q;
  core_req_t slot_d;

  always_comb begin
    full_d = full_q;
    slot_d = slot_q;
    if (drain_i) begin
      full_d = 1'b0;
    end
    if (load_i) begin
      full_d = 1'b1;
      slot_d = req_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      full_q <= 1'b0;
      slot_q <= '0;
    end else begin
      full_q <= full_d;
      slot_q <= slot_d;
    end
  end

  assign full_o = full_q;
  assign slot_o = slot_q;
endmodule
`default_nettype wire

// ### rtl/primary_bus_hold_arbiter.sv
// Primary bus yield arbiter: hands the bus to an external master
// Assumes phase1_clock is a synchronous level input of core_clk_i
`timescale 1ns/100ps
`default_nettype none
// Function
// RULE_01: Take asynchronous request, one cycle slack allowed
// RULE_02: Sample request, update grant on phase-1 fall
// RULE_03: No primary-bus accesses while request asserted
// RULE_04: Core runs until bus access, then stalls
// RULE_05: Post first write, stall on second
// RULE_06: Disable bit overrides the request
// RULE_07: Disable bit ends hold, blocks new ones
// RULE_08: Grant low until one cycle after release
// RULE_09: Drive strobe high before releasing it
// RULE_10: Float strobe, rw, address, data during hold
// RULE_11: Redrive strobe, rw, address on phase-1 fall
// RULE_12: Master drives only while grant low
module primary_bus_hold_arbiter
  import bus_yield_pkg::*;
(
  input  wire logic      core_clk_i,
  input  wire logic      rst_i,
  input  wire logic      phase1_clock_i,
  input  wire logic      hold_req_n_i,
  input  wire logic      yield_disable_i,
  input  wire logic      post_write_en_i,
  input  wire core_req_t core_req_i,
  output logic           core_stall_o,
  output logic           bus_yield_grant_n_o,
  output logic           bus_busy_o,
  output bus_drive_t     bus_o
);
  yield_state_t state_q;
  yield_state_t state_d;
  logic         ph1_q;
  logic         ph1_fall;
  logic         req_sampled;
  logic         req_eff;
  logic         grant_n_q;
  logic         grant_n_d;
  logic         slot_full;
  logic         slot_load;
  logic         slot_drain;
  core_req_t    slot_req;
  bus_drive_t   bus_q;
  bus_drive_t   bus_d;
  logic         core_access;
  logic         yielding;
  logic         ph1_d;
  logic [1:0]   tail_cnt_q;
  logic [1:0]   tail_cnt_d;
  logic         tail_done;

  // Phase-1 falling edge between two samples
  function automatic logic fall_of(input logic prev, input logic cur);
    fall_of = prev & ~cur;
  endfunction

  // States that keep the core off the bus
  function automatic logic core_blocked(input yield_state_t s);
    case (s)
      ST_OWN:  core_blocked = 1'b0;
      default: core_blocked = 1'b1;
    endcase
  endfunction

  // States in which the bus is being handed to or may be owned by the far master
  function automatic logic is_yielding(input yield_state_t s);
    case (s)
      ST_OWN:    is_yielding = 1'b0;
      ST_RESUME: is_yielding = 1'b0;
      default:   is_yielding = 1'b1;
    endcase
  endfunction

  // States in which the grant stands low
  function automatic logic grant_held(input yield_state_t s);
    case (s)
      ST_YIELDED:    grant_held = 1'b1;
      ST_GRANT_TAIL: grant_held = 1'b1;
      default:       grant_held = 1'b0;
    endcase
  endfunction

  // Bus image of one access taken from a request
  function automatic bus_drive_t drive_access(input core_req_t r);
    drive_access          = '0;
    drive_access.strobe_n = 1'b0;
    drive_access.rw       = ~r.wr;
    drive_access.addr     = r.addr;
    drive_access.data     = r.wdata;
    drive_access.ctl_oe   = 1'b1;
    drive_access.data_oe  = r.wr;
  endfunction

  // Phase-1 level history
  always_comb begin
    ph1_d = phase1_clock_i;
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph1_q <= 1'b0;
    end else begin
      ph1_q <= ph1_d;
    end
  end

  assign ph1_fall = fall_of(ph1_q, phase1_clock_i);

  // RULE_01: sampled request
  yield_request_sampler u_sampler (
    .core_clk_i    (core_clk_i),
    .rst_i         (rst_i),
    .phase1_fall_i (ph1_fall),
    .hold_req_n_i  (hold_req_n_i),
    .hold_req_o    (req_sampled)
  );

  // RULE_06: disable overrides request
  assign req_eff = req_sampled & ~yield_disable_i;

  assign core_access = core_req_i.rd | core_req_i.wr;
  assign yielding    = is_yielding(state_q);

  // RULE_05: post first write during hold
  assign slot_load  = yielding & post_write_en_i & core_req_i.wr & ~slot_full;
  assign slot_drain = (state_q == ST_OWN) & slot_full;

  pending_write_slot u_slot (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .load_i     (slot_load),
    .req_i      (core_req_i),
    .drain_i    (slot_drain),
    .full_o     (slot_full),
    .slot_o     (slot_req)
  );

  // RULE_04: stall core on bus access during hold
  always_comb begin
    core_stall_o = 1'b0;
    // RULE_03: hold off core on sampled request
    if (core_blocked(state_q)) begin
      core_stall_o = core_access & ~slot_load;
    end else if (slot_full || req_eff) begin
      core_stall_o = core_access;
    end
  end

  always_comb begin
    state_d   = state_q;
    case (state_q)
      ST_OWN: begin
        // RULE_09: strobe high on phase-1 fall
        if (ph1_fall && req_eff) begin
          state_d = ST_STROBE_HIGH;
        end
      end
      ST_STROBE_HIGH: begin
        // RULE_02: grant after phase-1 fall
        if (!req_eff) begin
          state_d = ST_RESUME;
        end else if (ph1_fall) begin
          state_d   = ST_YIELDED;
        end
      end
      ST_YIELDED: begin
        // RULE_07: disable ends hold
        if (yield_disable_i) begin
          state_d   = ST_RESUME;
        end else if (ph1_fall && !req_sampled) begin
          state_d = ST_GRANT_TAIL;
        end
      end
      ST_GRANT_TAIL: begin
        // RULE_08: one phase-1 cycle tail
        if (tail_done || yield_disable_i) begin
          state_d   = ST_RESUME;
        end
      end
      ST_RESUME: begin
        // RULE_11: redrive on phase-1 fall
        if (ph1_fall) begin
          state_d = ST_OWN;
        end
      end
      default: begin
        state_d   = ST_OWN;
      end
    endcase
  end

  // RULE_08: phase-1 cycles of grant tail
  always_comb begin
    tail_cnt_d = tail_cnt_q;
    if (state_q != ST_GRANT_TAIL) begin
      tail_cnt_d = 2'h0;
    end else if (ph1_fall && !tail_done) begin
      tail_cnt_d = tail_cnt_q + 2'h1;
    end
  end

  assign tail_done = ph1_fall && (tail_cnt_q == 2'(`GRANT_HOLD_CYC - 1));

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tail_cnt_q <= 2'h0;
    end else begin
      tail_cnt_q <= tail_cnt_d;
    end
  end

  // RULE_02: grant low only while yielded or in grant tail
  always_comb begin
    grant_n_d = ~grant_held(state_d);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      grant_n_q <= 1'b1;
    end else begin
      grant_n_q <= grant_n_d;
    end
  end

  always_comb begin
    bus_d          = bus_q;
    bus_d.strobe_n = 1'b1;
    bus_d.rw       = `RW_IDLE_VALUE;
    case (state_d)
      ST_OWN: begin
        bus_d.ctl_oe  = 1'b1;
        bus_d.data_oe = 1'b0;
        // RULE_03: access only when bus owned
        if (slot_drain) begin
          bus_d = drive_access(slot_req);
        end else if (core_access && state_q == ST_OWN && !req_eff) begin
          bus_d = drive_access(core_req_i);
        end
      end
      ST_STROBE_HIGH: begin
        bus_d.ctl_oe  = 1'b1;
        bus_d.data_oe = 1'b0;
      end
      ST_YIELDED, ST_GRANT_TAIL: begin
        // RULE_10: float strobe, rw, address, data
        bus_d.ctl_oe  = 1'b0;
        bus_d.data_oe = 1'b0;
      end
      ST_RESUME: begin
        bus_d.ctl_oe  = 1'b0;
        bus_d.data_oe = 1'b0;
      end
      default: begin
        bus_d.ctl_oe  = 1'b1;
        bus_d.data_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_OWN;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_q <= '{strobe_n: 1'b1, rw: 1'b1, addr: '0, data: '0, ctl_oe: 1'b1, data_oe: 1'b0};
    end else begin
      bus_q <= bus_d;
    end
  end

  assign bus_yield_grant_n_o = grant_n_q;
  assign bus_busy_o          = yielding;
  assign bus_o               = bus_q;
endmodule
`default_nettype wire

// ### rtl/yield_request_sampler.sv
// Samples the yield request on the phase-1 falling edge
// Assumes request is synchronous to core_clk_i
`timescale 1ns/100ps
`default_nettype none
module yield_request_sampler (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic phase1_fall_i,
  input  wire logic hold_req_n_i,
  output logic      hold_req_o
);
  logic req_q;
  logic req_d;

  always_comb begin
    req_d = req_q;
    if (phase1_fall_i) begin
      req_d = ~hold_req_n_i;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
    end else begin
      req_q <= req_d;
    end
  end

  assign hold_req_o = req_q;
endmodule
`default_nettype wire

// ### verif/bus_master_model.sv
// External master asking for the primary bus
// Assumes the bench calls hold from its sequence
`timescale 1ns/100ps
`default_nettype none
module bus_master_model (
  input  wire logic core_clk_i,
  input  wire logic grant_n_i,
  output var logic  hold_req_n_o
);
  initial hold_req_n_o = 1'b1;
  task automatic hold(input int cyc, output bit ok);
    @(negedge core_clk_i);
    hold_req_n_o = 1'b0;
    for (int n = 0; n < 40 && grant_n_i !== 1'b0; n++) @(negedge core_clk_i);
    ok = (grant_n_i === 1'b0);
    repeat (cyc) @(negedge core_clk_i);
    hold_req_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// ### verif/primary_bus_hold_arbiter_checker.sv
// Port assertions for the bus yield arbiter
// Assumes phase1 is a level on core_clk_i
`timescale 1ns/100ps
`default_nettype none
module primary_bus_hold_arbiter_checker
  import bus_yield_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  input wire logic       phase1_clock_i,
  input wire logic       hold_req_n_i,
  input wire logic       yield_disable_i,
  input wire logic       bus_yield_grant_n_o,
  input wire logic       bus_busy_o,
  input wire bus_drive_t bus_o
);
  logic ph_q;
  logic fall_w;
  assign fall_w = ph_q & ~phase1_clock_i;
  always_ff @(posedge core_clk_i or posedge rst_i)
    if (rst_i) ph_q <= 1'b0;
    else ph_q <= phase1_clock_i;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence on_fall_s;
    $past(fall_w) || $past(fall_w, 2);
  endsequence
  grant_off_a: assert property (yield_disable_i |=> bus_yield_grant_n_o)
    else $error("grant under disable");
  bus_float_a: assert property (!bus_yield_grant_n_o |-> !bus_o.ctl_oe && !bus_o.data_oe)
    else $error("bus driven");
  strobe_first_a: assert property ($fell(bus_o.ctl_oe) |-> $past(bus_o.strobe_n) && $past(bus_o.strobe_n, 2))
    else $error("strobe low");
  grant_edge_a: assert property ($fell(bus_yield_grant_n_o) |-> on_fall_s)
    else $error("grant edge");
  bus_resume_a: assert property ($rose(bus_o.ctl_oe) |-> on_fall_s)
    else $error("resume edge");
  grant_tail_a: assert property ($rose(hold_req_n_i) && !bus_yield_grant_n_o
    |=> !bus_yield_grant_n_o [*3] ##[1:24] bus_yield_grant_n_o) else $error("grant tail");
  grant_bound_a: assert property ($fell(hold_req_n_i) && !yield_disable_i && !bus_busy_o
    |-> ##[1:28] (!bus_yield_grant_n_o || hold_req_n_i)) else $error("grant late");
  no_access_a: assert property (!bus_o.strobe_n |-> bus_o.ctl_oe && bus_yield_grant_n_o)
    else $error("access in hold");
endmodule
bind primary_bus_hold_arbiter primary_bus_hold_arbiter_checker i_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .phase1_clock_i(phase1_clock_i),
  .hold_req_n_i(hold_req_n_i), .yield_disable_i(yield_disable_i),
  .bus_yield_grant_n_o(bus_yield_grant_n_o), .bus_busy_o(bus_busy_o), .bus_o(bus_o));
`default_nettype wire

// ### verif/primary_bus_hold_arbiter_tb.sv
// Bench for the bus yield arbiter
// Needs the bound checker and master model
`timescale 1ns/100ps
`default_nettype none
module primary_bus_hold_arbiter_tb
  import bus_yield_pkg::*;
;
  logic        core_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        hold_req_n_i;
  logic        yield_disable_i = 1'b0;
  logic        post_write_en_i = 1'b0;
  core_req_t   core_req_i = '0;
  logic        core_stall_o;
  logic        bus_yield_grant_n_o;
  bus_drive_t  bus_o;
  logic [1:0]  ph_cnt = 2'h0;
  logic [23:0] exp_a[$];
  logic        exp_g[$];
  logic [1:0]  exp_r[$];
  logic [31:0] exp_d[$];
  int          mismatches = 0;
  int          tests_run = 0;
  bit          ok;
  always #12.5 core_clk_i = ~core_clk_i;
  always @(negedge core_clk_i) ph_cnt <= ph_cnt + 2'h1;
  primary_bus_hold_arbiter i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .phase1_clock_i(ph_cnt[1]),
    .hold_req_n_i(hold_req_n_i), .yield_disable_i(yield_disable_i), .post_write_en_i(post_write_en_i),
    .core_req_i(core_req_i), .core_stall_o(core_stall_o), .bus_yield_grant_n_o(bus_yield_grant_n_o),
    .bus_busy_o(), .bus_o(bus_o));
  bus_master_model i_mst (.core_clk_i(core_clk_i), .grant_n_i(bus_yield_grant_n_o), .hold_req_n_o(hold_req_n_i));
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (e !== s) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic st);
    logic [23:0] a;
    logic [31:0] d;
    a = 24'($urandom);
    d = $urandom;
    exp_a.push_back(a);
    exp_r.push_back({~w, w});
    exp_d.push_back(w ? d : 32'h0);
    @(negedge core_clk_i);
    core_req_i = '{~w, w, a, d};
    #1 check("stall", 24'(st), 24'(core_stall_o));
    while (core_stall_o !== 1'b0) @(negedge core_clk_i);
    @(negedge core_clk_i);
    core_req_i = '0;
  endtask
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(bus_yield_grant_n_o)
    if (!rst_i) check("grant", 24'(exp_g.size() ? exp_g.pop_front() : 1'hX), 24'(bus_yield_grant_n_o));
  always @(negedge core_clk_i)
    if (bus_o.strobe_n === 1'b0) begin
      check("addr", exp_a.size() ? exp_a.pop_front() : 'X, bus_o.addr);
      check("rw", exp_r.size() ? exp_r.pop_front() : 2'hX, {bus_o.rw, bus_o.data_oe});
      check("data", exp_d.size() ? exp_d.pop_front() : 'X, bus_o.data_oe ? bus_o.data : 32'h0);
    end
  initial begin
    void'($urandom(32'h3427C38B));
    repeat (2) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (3) acc(1'($urandom), 1'b0);
    for (int k = 0; k < 2; k++) begin
      post_write_en_i = k[0];
      exp_g = '{1'b0, 1'b1};
      fork
        i_mst.hold(12, ok);
        begin
          wait (bus_yield_grant_n_o === 1'b0);
          if (k) acc(1'b1, 1'b0);
          acc(k[0], 1'b1);
        end
      join
    end
    exp_g = '{1'b0, 1'b1};
    fork
      i_mst.hold(20, ok);
      begin
        wait (bus_yield_grant_n_o === 1'b0);
        @(negedge core_clk_i);
        yield_disable_i = 1'b1;
      end
    join
    i_mst.hold(4, ok);
    check("refused", 24'h0, 24'(ok));
    repeat (8) @(negedge core_clk_i);
    yield_disable_i = 1'b0;
    acc(1'b0, 1'b0);
    repeat (8) @(negedge core_clk_i);
    check("left", 24'h0, 24'(exp_a.size() + exp_g.size() + exp_r.size() + exp_d.size()));
    complete_run();
  end
  initial begin
    #20000;
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire
